// ### asru_pkg.sv
// shared constants and types for the async serial receiver
package asru_pkg;
  localparam int ASRU_DATA_W = 8;
  localparam int ASRU_FIFO_DEPTH = 2;
  localparam int ASRU_OVS = 16;
  localparam logic [3:0] ASRU_MID_SAMPLE = 4'h7;
  localparam logic [3:0] ASRU_LAST_TICK = 4'hf;
  localparam logic [3:0] ASRU_BITS_8 = 4'h8;
  localparam logic [3:0] ASRU_BITS_9 = 4'h9;
  localparam logic [15:0] ASRU_DIV_RESET = 16'h0000;
  typedef enum logic [3:0] {
    ASRU_IDLE = 4'b0001,
    ASRU_START = 4'b0010,
    ASRU_DATA = 4'b0100,
    ASRU_STOP = 4'b1000
  } asru_state_t;
endpackage

// ### asru_tick_gen.sv
// oversample tick divider for the serial receiver
`timescale 1ns/10ps
module asru_tick_gen (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] div_value,
  output logic tick
);
  import asru_pkg::*;
  logic [15:0] cnt_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= ASRU_DIV_RESET;
    end else if (!run || cnt_q == div_value) begin
      cnt_q <= ASRU_DIV_RESET;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // one pulse each div_value+1 clocks
  assign tick = run && (cnt_q == div_value);
endmodule

// ### asru_fifo.sv
// small receive fifo carrying data, ninth bit and framing error per entry
`timescale 1ns/10ps
module asru_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic empty,
  output logic full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign empty = (cnt_q == '0);
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= nxt(wr_q);
      end
      if (do_pop) begin
        rd_q <= nxt(rd_q);
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // head entry feeds the status outputs; registered storage
  assign head_data = empty ? '0 : mem_q[rd_q];
endmodule

// ### asru_receiver.sv
// async serial receiver: line sampling, receive fifo and status flags
// Summary of operation
// - pending flag high while receiver enabled and fifo holds an unread character.
// - pending flag has no software write path; it follows fifo occupancy.
// - receive irq request needs rx, peripheral and global irq enables all set.
// - pending flag is computed without regard to any interrupt enable.
// - each stored character keeps its own framing error from the stop sample.
// - frame error output is read-only and shows the oldest unread character.
// - framing error never blocks reception; a data read exposes next status.
// - clearing port enable resets receiver and frame error; clearing rx enable resets the receiver and overrun flag but keeps frame error.
// - a framing error on its own raises no interrupt request.
// - frame error stays set across reads when all held characters have one.
// - fifo holds two characters; a complete third sets the overrun flag.
// - during overrun stored characters stay readable, new ones are refused.
// - overrun clears when continuous receive enable or port enable is cleared.
// - nine-bit select shifts nine data bits per character.
// - ninth-bit output shows the ninth data bit of the oldest character.
// - address detect enable selects address mode; needs nine-bit reception.
// - address mode stores only characters with ninth bit set; others dropped.
`timescale 1ns/10ps
module asru_receiver #(
  parameter int DATA_W = 8,
  parameter int FIFO_DEPTH = 2,
  parameter logic [15:0] DIV_DEFAULT = 16'h0033
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rx_line,
  input wire logic serial_port_enable,
  input wire logic continuous_rx_enable,
  input wire logic nine_bit_rx_select,
  input wire logic address_detect_enable,
  input wire logic [15:0] baud_div,
  input wire logic rx_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic rx_data_read,
  output logic [DATA_W-1:0] rx_data_reg,
  output logic rx_ninth_bit,
  output logic frame_error_flag,
  output logic overrun_error_flag,
  output logic rx_char_pending_flag,
  output logic rx_irq_req,
  output logic rx_busy
);
  import asru_pkg::*;

  localparam int ENTRY_W = DATA_W + 2;
  localparam int SHIFT_W = DATA_W + 1;

  // line synchroniser; the first stage is read only by the second
  logic line_meta_q;
  logic line_sync_q;
  logic line_prev_q;

  asru_state_t state_q;
  logic [3:0] ovs_q;
  logic [3:0] bit_cnt_q;
  logic [SHIFT_W-1:0] rx_shift_register_q;
  logic overrun_q;
  logic store_pulse_q;
  logic [ENTRY_W-1:0] store_entry_q;
  logic rx_on;
  logic tick;
  logic fifo_empty;
  logic fifo_full;
  logic fifo_pop;
  logic [ENTRY_W-1:0] head_entry;
  logic [3:0] bits_wanted;
  logic fall_edge;
  logic stop_ok;
  logic keep_char;
  logic [DATA_W-1:0] data_low;
  logic ninth_bit;
  logic start_mid;
  logic bit_end;
  logic last_bit;

  assign rx_on = serial_port_enable && continuous_rx_enable;
  assign bits_wanted = nine_bit_rx_select ? ASRU_BITS_9 : ASRU_BITS_8;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_meta_q <= 1'b1;
      line_sync_q <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      line_meta_q <= rx_line;
      line_sync_q <= line_meta_q;
      line_prev_q <= line_sync_q;
    end
  end

  assign fall_edge = line_prev_q && !line_sync_q;

  asru_tick_gen u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(rx_on && (state_q != ASRU_IDLE)),
    .div_value(baud_div),
    .tick(tick)
  );

  assign stop_ok = line_sync_q;

  // data bits arrive lsb first; align to the character length chosen
  always_comb begin
    data_low = '0;
    ninth_bit = 1'b0;
    if (nine_bit_rx_select) begin
      data_low = rx_shift_register_q[DATA_W-1:0];
      ninth_bit = rx_shift_register_q[SHIFT_W-1];
    end else begin
      data_low = rx_shift_register_q[SHIFT_W-1:1];
    end
  end

  // address mode only with nine-bit frames
  // drop characters whose ninth bit is clear
  assign keep_char = !(address_detect_enable && nine_bit_rx_select) || ninth_bit;

  // start-bit centre and bit-period end, shared by the sequencer's counters
  assign start_mid = tick && (ovs_q == ASRU_MID_SAMPLE);
  assign bit_end = tick && (ovs_q == ASRU_LAST_TICK);
  assign last_bit = (bit_cnt_q == bits_wanted - 4'h1);

  // receive sequencer; dropping either enable returns it to idle at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ASRU_IDLE;
    end else if (!rx_on) begin
      state_q <= ASRU_IDLE;
    end else begin
      case (state_q)
        ASRU_IDLE: begin
          if (fall_edge && !overrun_q) begin
            state_q <= ASRU_START;
          end
        end
        ASRU_START: begin
          // a start bit that is high again by its centre was only a glitch
          if (start_mid) begin
            state_q <= line_sync_q ? ASRU_IDLE : ASRU_DATA;
          end
        end
        ASRU_DATA: begin
          if (bit_end && last_bit) begin
            state_q <= ASRU_STOP;
          end
        end
        ASRU_STOP: begin
          if (bit_end) begin
            state_q <= ASRU_IDLE;
          end
        end
        default: begin
          state_q <= ASRU_IDLE;
        end
      endcase
    end
  end

  // oversample phase restarts at the start-bit centre, so later samples land mid-bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovs_q <= '0;
    end else if (!rx_on) begin
      ovs_q <= '0;
    end else begin
      case (state_q)
        ASRU_START: begin
          if (start_mid) begin
            ovs_q <= '0;
          end else if (tick) begin
            ovs_q <= ovs_q + 4'h1;
          end
        end
        ASRU_DATA, ASRU_STOP: begin
          if (tick) begin
            ovs_q <= ovs_q + 4'h1;
          end
        end
        default: begin
          ovs_q <= '0;
        end
      endcase
    end
  end

  // data bit counter, cleared while the start bit is checked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= '0;
    end else if (!rx_on || state_q == ASRU_START) begin
      bit_cnt_q <= '0;
    end else if (state_q == ASRU_DATA && bit_end) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_register_q <= '0;
    end else if (rx_on && state_q == ASRU_DATA && bit_end) begin
      rx_shift_register_q <= {line_sync_q, rx_shift_register_q[SHIFT_W-1:1]};
    end
  end

  // completion of a character at its stop sample
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_pulse_q <= 1'b0;
      store_entry_q <= '0;
    end else begin
      store_pulse_q <= rx_on && state_q == ASRU_STOP && tick &&
                       ovs_q == ASRU_LAST_TICK && keep_char;
      store_entry_q <= {!stop_ok, ninth_bit, data_low};
    end
  end

  // overrun on a third full character
  // cleared by either enable low
  // a store and a read in one cycle are fine; the read frees the slot first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else if (!rx_on) begin
      overrun_q <= 1'b0;
    end else if (store_pulse_q && fifo_full && !fifo_pop) begin
      overrun_q <= 1'b1;
    end
  end

  // a data read advances the fifo
  assign fifo_pop = rx_data_read && !fifo_empty;

  // port enable low flushes stored characters; rx enable alone keeps them
  asru_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(!serial_port_enable),
    .push(store_pulse_q && !overrun_q && (!fifo_full || fifo_pop)),
    .push_data(store_entry_q),
    .pop(fifo_pop),
    .head_data(head_entry),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // each entry keeps its own error
  assign frame_error_flag = head_entry[ENTRY_W-1];
  assign rx_ninth_bit = head_entry[DATA_W];
  assign rx_data_reg = head_entry[DATA_W-1:0];
  assign overrun_error_flag = overrun_q;
  assign rx_char_pending_flag = rx_on && !fifo_empty;
  assign rx_irq_req = rx_char_pending_flag && rx_irq_enable &&
                      peripheral_irq_enable && global_irq_enable;
  assign rx_busy = state_q != ASRU_IDLE;
endmodule

// ### asru_asserts.sv
// port checker for the serial receiver
`timescale 1ns/10ps
module asru_asserts #(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serial_port_enable,
  input wire logic continuous_rx_enable,
  input wire logic rx_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic rx_data_read,
  input wire logic [DATA_W-1:0] rx_data_reg,
  input wire logic rx_ninth_bit,
  input wire logic frame_error_flag,
  input wire logic overrun_error_flag,
  input wire logic rx_char_pending_flag,
  input wire logic rx_irq_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic rx_on;
  logic keep;
  assign rx_on = serial_port_enable && continuous_rx_enable;
  // no pop and no flush, so the head must not move
  assign keep = rx_char_pending_flag && !rx_data_read && serial_port_enable;
  sequence port_off2;
    !serial_port_enable ##1 !serial_port_enable;
  endsequence
  sequence rx_off2;
    !continuous_rx_enable ##1 !continuous_rx_enable;
  endsequence
  AST_IRQ_GATE:
  assert property (rx_irq_req == (rx_char_pending_flag && rx_irq_enable
    && peripheral_irq_enable && global_irq_enable)) else $error("irq gate");
  AST_PEND_OFF:
  assert property (!rx_on |-> !rx_char_pending_flag) else $error("pending while off");
  AST_EMPTY_ZERO:
  assert property (rx_on && !rx_char_pending_flag |-> rx_data_reg == '0) else $error("empty data");
  AST_PEND_HOLD:
  assert property (keep && continuous_rx_enable |=> rx_char_pending_flag || !rx_on)
    else $error("pending lost");
  AST_HEAD_HOLD:
  assert property (keep |=> $stable({rx_data_reg, rx_ninth_bit, frame_error_flag}))
    else $error("head moved");
  AST_PORT_CLR:
  assert property (port_off2 |-> !frame_error_flag && !overrun_error_flag) else $error("port clr");
  AST_RX_OFF_CLR:
  assert property (rx_off2 |-> !overrun_error_flag) else $error("rx off clr");
  AST_OVR_HOLD:
  assert property (overrun_error_flag && rx_on |=> overrun_error_flag) else $error("ovr lost");
endmodule
bind asru_receiver asru_asserts #(.DATA_W(DATA_W)) asru_chk (.core_clk, .rst_n,
  .serial_port_enable, .continuous_rx_enable, .rx_irq_enable, .peripheral_irq_enable,
  .global_irq_enable, .rx_data_read, .rx_data_reg, .rx_ninth_bit, .frame_error_flag,
  .overrun_error_flag, .rx_char_pending_flag, .rx_irq_req);

// ### asru_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/10ps
module asru_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic core_clk,
  output logic serial_line
);
  initial serial_line = 1'b1;
  // lsb first; a trailing idle bit gives the next start a clean falling edge
  task automatic send(input logic [8:0] val, input logic nine, input logic bad_stop);
    logic [11:0] frame;
    frame = nine ? {1'b1, ~bad_stop, val, 1'b0} : {2'h3, ~bad_stop, val[7:0], 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk) serial_line <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge core_clk);
    end
  endtask
endmodule

// ### tb.sv
// self-checking bench for the serial receiver
`timescale 1ns/10ps
module tb;
  import asru_pkg::*;
  localparam logic [15:0] DIV = 16'h0001;
  logic core_clk, rst_n, rx_line, serial_port_enable, continuous_rx_enable, nine_bit_rx_select;
  logic address_detect_enable, rx_irq_enable, peripheral_irq_enable, global_irq_enable;
  logic rx_data_read, rx_ninth_bit, frame_error_flag, overrun_error_flag, rx_char_pending_flag;
  logic rx_irq_req, rx_busy;
  logic [ASRU_DATA_W-1:0] rx_data_reg;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  asru_receiver uut (.core_clk, .rst_n, .rx_line, .serial_port_enable, .continuous_rx_enable,
    .nine_bit_rx_select, .address_detect_enable, .baud_div(DIV), .rx_irq_enable,
    .peripheral_irq_enable, .global_irq_enable, .rx_data_read, .rx_data_reg, .rx_ninth_bit,
    .frame_error_flag, .overrun_error_flag, .rx_char_pending_flag, .rx_irq_req, .rx_busy);
  asru_tx_model #(.BIT_CLKS((DIV + 1) * ASRU_OVS)) far_tx (.core_clk, .serial_line(rx_line));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // packed as port, continuous rx, nine-bit, address detect
  task automatic set_en(input logic [3:0] en);
    @(posedge core_clk);
    {serial_port_enable, continuous_rx_enable, nine_bit_rx_select, address_detect_enable} <= en;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic flags(input logic [3:0] exp);
    @(negedge core_clk);
    chk("flags", {6'h00, exp},
      {6'h00, overrun_error_flag, frame_error_flag, rx_char_pending_flag, rx_irq_req});
  endtask
  // status is taken before the pop, since the pop moves the head
  task automatic rd_char(input logic [9:0] exp);
    @(negedge core_clk);
    chk("head", exp, {frame_error_flag, rx_ninth_bit, rx_data_reg});
    @(posedge core_clk) rx_data_read <= 1'b1;
    @(posedge core_clk) rx_data_read <= 1'b0;
  endtask
  task automatic tx(input logic [8:0] v, input logic bad);
    far_tx.send(v, nine_bit_rx_select, bad);
  endtask
  // sends a good frame and looks at the busy output in the middle of it
  task automatic tx_busy(input logic [8:0] v, input logic exp);
    fork
      tx(v, 1'b0);
      begin
        repeat (100) @(posedge core_clk);
        @(negedge core_clk);
        chk("busy", {9'h000, exp}, {9'h000, rx_busy});
      end
    join
  endtask
  task automatic t_basic;
    set_en(4'hc);
    tx_busy(9'h0a5, 1'b1);
    flags(4'h2);
    @(posedge core_clk) global_irq_enable <= 1'b1;
    flags(4'h3);
    rd_char(10'h0a5);
    flags(4'h0);
    $display("basic done");
  endtask
  task automatic t_frame_error_flag;
    tx(9'h03c, 1'b1);
    tx(9'h081, 1'b1);
    set_en(4'h8);
    tx_busy(9'h0ff, 1'b0);
    flags(4'h4);
    set_en(4'hc);
    rd_char(10'h23c);
    rd_char(10'h281);
    tx(9'h0e7, 1'b0);
    rd_char(10'h0e7);
    tx(9'h011, 1'b1);
    set_en(4'h4);
    flags(4'h0);
    $display("framing done");
  endtask
  task automatic t_ovr;
    set_en(4'hc);
    tx(9'h011, 1'b0);
    tx(9'h022, 1'b0);
    tx(9'h033, 1'b0);
    flags(4'hb);
    tx(9'h044, 1'b0);
    rd_char(10'h011);
    rd_char(10'h022);
    flags(4'h8);
    set_en(4'h8);
    flags(4'h0);
    $display("overrun done");
  endtask
  task automatic t_nine;
    set_en(4'he);
    tx(9'h1c3, 1'b0);
    tx(9'h05a, 1'b0);
    rd_char(10'h1c3);
    rd_char(10'h05a);
    set_en(4'hf);
    tx(9'h055, 1'b0);
    flags(4'h0);
    tx(9'h1aa, 1'b0);
    rd_char(10'h1aa);
    set_en(4'he);
    tx(9'h033, 1'b0);
    rd_char(10'h033);
    $display("nine-bit done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    {serial_port_enable, continuous_rx_enable, nine_bit_rx_select, address_detect_enable} = 4'h0;
    {rx_irq_enable, peripheral_irq_enable, global_irq_enable, rx_data_read} = 4'hc;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_basic;
    t_frame_error_flag;
    t_ovr;
    t_nine;
    wrap_up;
  end
  // a hang in any wait ends the run through the same report
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up;
    end
  end
endmodule
